// *** core/edit_engine_defs.vh ***
// Purpose: constants for the packed decimal edit engine
// Assumes: byte addresses on a 32-bit AXI4-Lite register bus
// Notes: definitions only
`ifndef EDIT_ENGINE_DEFS_VH
`define EDIT_ENGINE_DEFS_VH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SRCLEN 8'h08
`define REG_SRCADDR 8'h0c
`define REG_PATADDR 8'h10
`define REG_DSTADDR 8'h14
`define REG_DIGIT_COUNT 8'h18
`define REG_SOURCE_PTR 8'h1c
`define REG_CHAR_HOLDING 8'h20
`define REG_PATTERN_PTR 8'h24
`define REG_SCRATCH 8'h28
`define REG_DEST_PTR 8'h2c
// control fields
`define CTRL_START 0
`define CTRL_DV 1
// status fields
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ABORT 2
`define ST_FAULT 3
`define ST_OVF_TRAP 4
`define ST_FPD 5
`define ST_C 6
`define ST_V 7
`define ST_Z 8
`define ST_N 9
// limits and characters
`define MAX_SRCLEN 16'h001f
`define CHAR_BLANK 8'h20
`define CHAR_MINUS 8'h2d
`define CHAR_ZERO 8'h30
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// pattern operator codes
`define OP_FINISH 8'h00
`define OP_END_FLOAT 8'h01
`define OP_CLR_SIGNIF 8'h02
`define OP_SET_SIGNIF 8'h03
`define OP_STORE_SIGN 8'h04
`define OP_LOAD_FILL 8'h40
`define OP_LOAD_SIGN 8'h41
`define OP_SIGN_IF_POS 8'h42
`define OP_SIGN_IF_NEG 8'h43
`define OP_INSERT_CHAR 8'h44
`define OP_BLANK_IF_NULL 8'h45
`define OP_NEGZERO_FIX 8'h46
`define OP_LEN_ADJUST 8'h47
`define NIB_FILL 4'h8
`define NIB_MOVE 4'h9
`define NIB_FLOAT 4'ha
`endif

// *** core/packed_decimal_edit_engine.v ***
// Purpose: edit engine turning a packed decimal source into characters under a pattern
// Assumes: one memory port, request held until mem_ready; rdata valid with ready
// Notes: software loads operands and starts the engine over AXI4-Lite
// Behaviour
// - abort before editing when length exceeds 31
// - operators 40-47 fetch next byte as operand
// - 80-AF take repeat count from low nibble
// - reserved code faults, pointer kept, resume flag set
// - sign in bits 15:8, fill in 7:0
// - count holds remaining length and negated zero count
// - pattern pointer addresses faulting operator
// - each store writes one byte, pointer plus one except negzero fix
// - leftover digits after finish cause abort
// - completion restores count, rewinds source, clears registers
// - zero result at completion clears negative code
// - reading past source aborts, count becomes -1
// - leftover-digit abort leaves pointer at finish operator
// - overflow with trap enable raises overflow trap
// - zero count aborts read; negative count supplies zero
// - nibble chosen by count bit 0, pointer advances after low nibble
// - zero, overflow, carry codes track digits and significance
// - insert stores operand if significant, else fill
// - sign loads 42/43 depend on source sign
// - digit move stores fill for insignificant digits
// - blank-if-null overwrites trailing bytes when zero
// - negzero fix overwrites byte operand places back with fill when minus zero
// - fill store writes fill repeat-count times
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`include "edit_engine_defs.vh"
`default_nettype none
module packed_decimal_edit_engine (
  input wire sys_clk, // core clock
  input wire rst, // synchronous reset, active high
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte enables
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  output reg mem_req, // memory request, held until mem_ready
  output reg mem_we, // 1 store, 0 load
  output reg [31:0] mem_addr, // byte address
  output reg [7:0] mem_wdata, // store byte
  input wire [7:0] mem_rdata, // load byte, valid with mem_ready
  input wire mem_ready // access completes
);
  localparam S_IDLE = 4'h0;
  localparam S_SIGN = 4'h1;
  localparam S_FETCH = 4'h2;
  localparam S_OPND = 4'h3;
  localparam S_EXEC = 4'h4;
  localparam S_DIG = 4'h5;
  localparam S_DRD = 4'h6;
  localparam S_USE = 4'h7;
  localparam S_ST = 4'h8;
  localparam S_NEXT = 4'h9;
  localparam S_FIN = 4'ha;

  reg [31:0] srcaddr_q, pataddr_q, dstaddr_q;
  reg [15:0] srclen_q, tmp1_q;
  reg dv_en_q, start_q;
  reg [31:0] digit_count_q, source_ptr_q, pattern_ptr_q, scratch_q, dest_ptr_q;
  reg [7:0] sign_q, fill_q, op_q, opnd_q, pend_char_q;
  reg [3:0] state_q, dig_q;
  reg n_q, z_q, v_q, c_q, busy_q, done_q, abort_q, fault_q, trap_q, fpd_q, pend_q;
  reg aw_got_q, w_got_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;

  wire [31:0] char_holding = {16'h0000, sign_q, fill_q};
  wire [7:0] cnt = scratch_q[7:0];
  wire [7:0] dig_char = `CHAR_ZERO + {4'h0, dig_q};
  wire dig_nz = (dig_q != 4'h0);
  wire [3:0] op_hi = op_q[7:4];

  // legal operator check at decode time
  function op_legal;
    input [7:0] op;
    begin
      op_legal = (op <= `OP_STORE_SIGN) || (op[7:3] == 5'b01000) ||
        ((op[7:4] == `NIB_FILL || op[7:4] == `NIB_MOVE || op[7:4] == `NIB_FLOAT) &&
        (op[3:0] != 4'h0));
    end
  endfunction

  // launch one memory access; only one outstanding at a time
  task issue;
    input we;
    input [31:0] a;
    input [7:0] d;
    begin
      mem_req <= 1'b1;
      mem_we <= we;
      mem_addr <= a;
      mem_wdata <= d;
    end
  endtask

  // begin a store; adv selects the pointer increment
  reg st_adv_q;
  task store;
    input [31:0] a;
    input [7:0] ch;
    input adv;
    begin
      issue(1'b1, a, ch);
      st_adv_q <= adv;
      state_q <= S_ST;
    end
  endtask

  // bus handshakes: one write and one read at a time
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // register write side; operand registers only steer the next start
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      dv_en_q <= 1'b0;
      start_q <= 1'b0;
      srclen_q <= 16'h0;
      srcaddr_q <= 32'h0;
      pataddr_q <= 32'h0;
      dstaddr_q <= 32'h0;
    end
    else
    begin
      start_q <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
      end
      if (aw_got_q && w_got_q)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        // byte enables ignored: every field is written as a whole word
        case (aw_addr_q)
          `REG_CTRL:
          begin
            dv_en_q <= w_data_q[`CTRL_DV];
            start_q <= w_data_q[`CTRL_START] && !busy_q;
          end
          `REG_SRCLEN: srclen_q <= w_data_q[15:0];
          `REG_SRCADDR: srcaddr_q <= w_data_q;
          `REG_PATADDR: pataddr_q <= w_data_q;
          `REG_DSTADDR: dstaddr_q <= w_data_q;
          `REG_STATUS, `REG_DIGIT_COUNT, `REG_SOURCE_PTR, `REG_CHAR_HOLDING,
          `REG_PATTERN_PTR, `REG_SCRATCH, `REG_DEST_PTR: s_axi_bresp <= `RESP_OKAY;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // register read side, answered one cycle after the address
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (s_axi_araddr)
        `REG_CTRL: s_axi_rdata <= {30'h0, dv_en_q, 1'b0};
        `REG_STATUS: s_axi_rdata <= {22'h0, n_q, z_q, v_q, c_q, fpd_q, trap_q, fault_q, abort_q, done_q, busy_q};
        `REG_SRCLEN: s_axi_rdata <= {16'h0, srclen_q};
        `REG_SRCADDR: s_axi_rdata <= srcaddr_q;
        `REG_PATADDR: s_axi_rdata <= pataddr_q;
        `REG_DSTADDR: s_axi_rdata <= dstaddr_q;
        `REG_DIGIT_COUNT: s_axi_rdata <= digit_count_q;
        `REG_SOURCE_PTR: s_axi_rdata <= source_ptr_q;
        `REG_CHAR_HOLDING: s_axi_rdata <= char_holding;
        `REG_PATTERN_PTR: s_axi_rdata <= pattern_ptr_q;
        `REG_SCRATCH: s_axi_rdata <= scratch_q;
        `REG_DEST_PTR: s_axi_rdata <= dest_ptr_q;
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // edit sequencer: fetch, decode, execute one pattern operator at a time
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0;
      mem_wdata <= 8'h00;
      digit_count_q <= 32'h0;
      source_ptr_q <= 32'h0;
      pattern_ptr_q <= 32'h0;
      scratch_q <= 32'h0;
      dest_ptr_q <= 32'h0;
      sign_q <= 8'h00;
      fill_q <= 8'h00;
      op_q <= 8'h00;
      opnd_q <= 8'h00;
      pend_char_q <= 8'h00;
      dig_q <= 4'h0;
      tmp1_q <= 16'h0;
      {n_q, z_q, v_q, c_q} <= 4'h0;
      {busy_q, done_q, abort_q, fault_q, trap_q, fpd_q, pend_q, st_adv_q} <= 8'h00;
    end
    else
    begin
      if (mem_req && mem_ready)
        mem_req <= 1'b0;
      case (state_q)
        S_IDLE:
        if (start_q && fpd_q)
        begin
          // resume a faulted edit with all state kept
          {done_q, abort_q, fault_q, trap_q, fpd_q} <= 5'h00;
          busy_q <= 1'b1;
          issue(1'b0, pattern_ptr_q, 8'h00);
          state_q <= S_FETCH;
        end
        else if (start_q)
        begin
          {done_q, abort_q, fault_q, trap_q} <= 4'h0;
          if (srclen_q > `MAX_SRCLEN)
            abort_q <= 1'b1;
          else
          begin
            busy_q <= 1'b1;
            {v_q, c_q, z_q} <= 3'b001;
            digit_count_q <= {16'h0, srclen_q};
            tmp1_q <= srclen_q;
            source_ptr_q <= srcaddr_q;
            pattern_ptr_q <= pataddr_q;
            dest_ptr_q <= dstaddr_q;
            fill_q <= `CHAR_BLANK;
            // the sign nibble sits low in the last source byte
            issue(1'b0, srcaddr_q + {28'h0, srclen_q[4:1]}, 8'h00);
            state_q <= S_SIGN;
          end
        end
        S_SIGN:
        if (mem_ready)
        begin
          n_q <= (mem_rdata[3:0] == 4'hb) || (mem_rdata[3:0] == 4'hd);
          sign_q <= ((mem_rdata[3:0] == 4'hb) || (mem_rdata[3:0] == 4'hd)) ? `CHAR_MINUS : `CHAR_BLANK;
          issue(1'b0, pattern_ptr_q, 8'h00);
          state_q <= S_FETCH;
        end
        S_FETCH:
        if (mem_ready)
        begin
          op_q <= mem_rdata;
          if (!op_legal(mem_rdata))
          begin
            // pointer still on the operator so software can resume
            fault_q <= 1'b1;
            fpd_q <= 1'b1;
            busy_q <= 1'b0;
            state_q <= S_IDLE;
          end
          else if (mem_rdata[7:3] == 5'b01000)
          begin
            pattern_ptr_q <= pattern_ptr_q + 32'h1;
            issue(1'b0, pattern_ptr_q + 32'h1, 8'h00);
            state_q <= S_OPND;
          end
          else
            state_q <= S_EXEC;
        end
        S_OPND:
        if (mem_ready)
        begin
          opnd_q <= mem_rdata;
          state_q <= S_EXEC;
        end
        S_EXEC:
        begin
          state_q <= S_NEXT;
          scratch_q <= {28'h0, op_q[3:0]};
          case (op_q)
            `OP_FINISH:
            if (digit_count_q != 32'h0)
            begin
              abort_q <= 1'b1;
              busy_q <= 1'b0;
              state_q <= S_IDLE;
            end
            else
              state_q <= S_FIN;
            `OP_END_FLOAT:
            if (!c_q)
            begin
              c_q <= 1'b1;
              store(dest_ptr_q, sign_q, 1'b1);
            end
            `OP_CLR_SIGNIF: c_q <= 1'b0;
            `OP_SET_SIGNIF: c_q <= 1'b1;
            `OP_STORE_SIGN: store(dest_ptr_q, sign_q, 1'b1);
            `OP_LOAD_FILL: fill_q <= opnd_q;
            `OP_LOAD_SIGN: sign_q <= opnd_q;
            `OP_SIGN_IF_POS: if (!n_q) sign_q <= opnd_q;
            `OP_SIGN_IF_NEG: if (n_q) sign_q <= opnd_q;
            `OP_INSERT_CHAR: store(dest_ptr_q, c_q ? opnd_q : fill_q, 1'b1);
            `OP_BLANK_IF_NULL:
            if (z_q)
            begin
              // step back, then refill forward to where we were
              scratch_q <= {24'h0, opnd_q};
              dest_ptr_q <= dest_ptr_q - {24'h0, opnd_q};
              store(dest_ptr_q - {24'h0, opnd_q}, fill_q, 1'b1);
            end
            `OP_NEGZERO_FIX:
            if (n_q && z_q)
              store(dest_ptr_q - {24'h0, opnd_q}, fill_q, 1'b0);
            `OP_LEN_ADJUST:
            if (digit_count_q[15:0] > {8'h0, opnd_q})
            begin
              digit_count_q[31:16] <= 16'h0;
              scratch_q <= {16'h0, digit_count_q[15:0] - {8'h0, opnd_q}};
              state_q <= S_DIG;
            end
            else
              digit_count_q[31:16] <= digit_count_q[15:0] - {8'h0, opnd_q};
            default:
            if (op_hi == `NIB_FILL)
              store(dest_ptr_q, fill_q, 1'b1);
            else
              state_q <= S_DIG;
          endcase
        end
        S_DIG:
        if (digit_count_q == 32'h0)
        begin
          // pattern wants more digits than the source holds
          digit_count_q <= 32'hffffffff;
          abort_q <= 1'b1;
          busy_q <= 1'b0;
          state_q <= S_IDLE;
        end
        else if (digit_count_q[31])
        begin
          dig_q <= 4'h0;
          digit_count_q[31:16] <= digit_count_q[31:16] + 16'h1;
          state_q <= S_USE;
        end
        else
        begin
          issue(1'b0, source_ptr_q, 8'h00);
          state_q <= S_DRD;
        end
        S_DRD:
        if (mem_ready)
        begin
          dig_q <= digit_count_q[0] ? mem_rdata[7:4] : mem_rdata[3:0];
          digit_count_q <= digit_count_q - 32'h1;
          if (!digit_count_q[0])
            source_ptr_q <= source_ptr_q + 32'h1;
          state_q <= S_USE;
        end
        S_USE:
        begin
          if (dig_nz)
            z_q <= 1'b0;
          if (op_q == `OP_LEN_ADJUST)
          begin
            if (dig_nz)
              {c_q, v_q} <= 2'b11;
            scratch_q <= scratch_q - 32'h1;
            state_q <= (cnt == 8'h01) ? S_NEXT : S_DIG;
          end
          else if (op_hi == `NIB_MOVE)
          begin
            if (dig_nz)
              c_q <= 1'b1;
            store(dest_ptr_q, (c_q || dig_nz) ? dig_char : fill_q, 1'b1);
          end
          else if (dig_nz && !c_q)
          begin
            // floating sign goes out ahead of the first significant digit
            c_q <= 1'b1;
            pend_q <= 1'b1;
            pend_char_q <= dig_char;
            store(dest_ptr_q, sign_q, 1'b1);
          end
          else
            store(dest_ptr_q, c_q ? dig_char : fill_q, 1'b1);
        end
        S_ST:
        if (mem_ready)
        begin
          if (st_adv_q)
            dest_ptr_q <= dest_ptr_q + 32'h1;
          if (pend_q)
          begin
            pend_q <= 1'b0;
            store(dest_ptr_q + 32'h1, pend_char_q, 1'b1);
          end
          else if ((op_hi == `NIB_FILL || op_q == `OP_BLANK_IF_NULL) && cnt != 8'h01)
          begin
            scratch_q <= scratch_q - 32'h1;
            store(dest_ptr_q + 32'h1, fill_q, 1'b1);
          end
          else if ((op_hi == `NIB_MOVE || op_hi == `NIB_FLOAT) && cnt != 8'h01)
          begin
            scratch_q <= scratch_q - 32'h1;
            state_q <= S_DIG;
          end
          else
            state_q <= S_NEXT;
        end
        S_NEXT:
        begin
          pattern_ptr_q <= pattern_ptr_q + 32'h1;
          issue(1'b0, pattern_ptr_q + 32'h1, 8'h00);
          state_q <= S_FETCH;
        end
        S_FIN:
        begin
          digit_count_q <= {16'h0, tmp1_q};
          source_ptr_q <= source_ptr_q - {28'h0, tmp1_q[4:1]};
          sign_q <= 8'h00;
          fill_q <= 8'h00;
          scratch_q <= 32'h0;
          if (z_q)
            n_q <= 1'b0;
          trap_q <= v_q && dv_en_q;
          done_q <= 1'b1;
          busy_q <= 1'b0;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** testbench/edit_engine_sva.sv ***
// Purpose: port checks for the packed decimal edit engine
// Assumes: single clock, synchronous active-high reset
// Notes: bound to the engine below the module
`include "edit_engine_defs.vh"
`default_nettype none
module edit_engine_chk (
  input wire logic sys_clk, // core clock
  input wire logic rst, // reset
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic mem_req, // memory request
  input wire logic mem_we, // store select
  input wire logic [31:0] mem_addr, // byte address
  input wire logic [7:0] mem_wdata, // store byte
  input wire logic mem_ready // access done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic wr_hs;
  logic [15:0] len_q;
  // assumes address and data are taken at one edge
  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // last source length written, so an over-long start can be caught
  always @(posedge sys_clk)
  begin
    if (rst)
      len_q <= 16'h0000;
    else if (wr_hs && s_axi_awaddr == `REG_SRCLEN)
      len_q <= s_axi_wdata[15:0];
  end
  sequence s_long_start;
    wr_hs && s_axi_awaddr == `REG_CTRL && s_axi_wdata[`CTRL_START] && len_q > `MAX_SRCLEN;
  endsequence
  sequence s_quiet;
    !mem_req [*8];
  endsequence
  property p_long_abort;
    s_long_start |=> s_quiet;
  endproperty
  a_long_abort: assert property (p_long_abort) else $error("memory used after long source");
  property p_req_hold;
    mem_req && !mem_ready |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed early");
  // a new access may follow at once, but never a replay of the finished one
  property p_req_gap;
    mem_req && mem_ready |=> !mem_req || $changed(mem_addr) || $changed(mem_we);
  endproperty
  a_req_gap: assert property (p_req_gap) else $error("memory request repeated");
  property p_wr_answer;
    wr_hs |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken with response pending");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read data late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_block: assert property (p_r_block) else $error("read taken with data pending");
endmodule
bind packed_decimal_edit_engine edit_engine_chk edit_engine_chk_i (.*);
`default_nettype wire

// *** testbench/edit_mem_model.sv ***
// Purpose: byte memory holding source, pattern and destination
// Assumes: the engine holds each request until mem_ready
// Notes: slow adds wait states; load data is scrambled outside the ready cycle
`default_nettype none
module edit_mem_model (
  input wire logic sys_clk, // core clock
  input wire logic slow, // 1 adds wait states
  input wire logic mem_req, // request
  input wire logic mem_we, // store select
  input wire logic [31:0] mem_addr, // byte address
  input wire logic [7:0] mem_wdata, // store byte
  output var logic [7:0] mem_rdata, // load byte
  output var logic mem_ready // access done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [1:0] wait_q;
  // known start for the scramble
  initial
  begin
    mem_rdata = 8'h5a;
    mem_ready = 1'b0;
    wait_q = 2'h0;
  end
  // one access at a time; read data only means something with ready
  always @(posedge sys_clk)
  begin
    mem_ready <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ready)
    begin
      wait_q <= wait_q + 2'h1;
      if (wait_q >= {slow, 1'b0})
      begin
        wait_q <= 2'h0;
        mem_ready <= 1'b1;
        if (mem_we)
          mem[mem_addr[7:0]] <= mem_wdata;
        else
          mem_rdata <= mem[mem_addr[7:0]];
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: register-level tests of the packed decimal edit engine
// Assumes: operands placed in a 256-byte memory model
// Notes: expected values are worked out by hand from the edit rules
`include "edit_engine_defs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] src_a = 32'h0000_0010;
  localparam logic [31:0] pat_a = 32'h0000_0040;
  localparam logic [31:0] dst_a = 32'h0000_0080;
  logic sys_clk = 1'b0, rst = 1'b1, slow = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_req, mem_we, mem_ready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, mem_addr, st;
  logic [7:0] mem_wdata, mem_rdata;
  int miscompares = 0;
  int compares = 0;
  // byte enables unused: every register is written as a whole word
  packed_decimal_edit_engine packed_decimal_edit_engine_i (.*, .s_axi_wstrb(4'hf));
  edit_mem_model edit_mem_model_i (.*);
  // 250 MHz core clock
  always #2 sys_clk = ~sys_clk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ready read at the falling edge, where it has settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ta, tw;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(negedge sys_clk);
    for (n = 0; n < 64 && (s_axi_awvalid || s_axi_wvalid); n++)
    begin
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge sys_clk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      @(negedge sys_clk);
    end
    for (n = 0; n < 64 && !s_axi_bvalid; n++) @(negedge sys_clk);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(negedge sys_clk);
    for (n = 0; n < 64 && !s_axi_arready; n++) @(negedge sys_clk);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    @(negedge sys_clk);
    for (n = 0; n < 64 && !s_axi_rvalid; n++) @(negedge sys_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string w);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(w, e, d);
  endtask
  // bytes are listed first-address-first, right-aligned in v
  task automatic put(input logic [31:0] a, input int n, input logic [127:0] v);
    for (int i = 0; i < n; i++) edit_mem_model_i.mem[a[7:0] + i] = v[8*(n-1-i) +: 8];
  endtask
  task automatic chk_dst(input int n, input logic [127:0] v);
    for (int i = 0; i < n; i++) chk("dest byte", {24'h0, v[8*(n-1-i) +: 8]}, {24'h0, edit_mem_model_i.mem[dst_a[7:0] + i]});
  endtask
  task automatic go(input logic [31:0] ctrl);
    logic [1:0] r;
    int n;
    wr(`REG_CTRL, ctrl, `RESP_OKAY);
    st = 32'h1;
    for (n = 0; n < 300 && st[`ST_BUSY] !== 1'b0; n++) rd(`REG_STATUS, st, r);
  endtask
  task automatic run(input logic [15:0] len, input logic [31:0] ctrl);
    wr(`REG_SRCLEN, {16'h0000, len}, `RESP_OKAY);
    wr(`REG_SRCADDR, src_a, `RESP_OKAY);
    wr(`REG_PATADDR, pat_a, `RESP_OKAY);
    wr(`REG_DSTADDR, dst_a, `RESP_OKAY);
    go(ctrl);
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // a hang costs one mismatch and ends the run
  initial
  begin
    #200000;
    miscompares++;
    conclude();
  end
  // main sequence; patterns keep counts in 1..15 and lengths in 1..255
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rc(`REG_STATUS, 32'h0, "status at reset");
    rd(8'h30, d, r);
    chk("unmapped read", 32'h2, {30'h0, r});
    wr(8'h30, 32'h1, `RESP_SLVERR);
    slow <= 1'b1;
    put(src_a, 3, 128'h00123c);
    put(pat_a, 12, 128'h402a814326422b442c950400);
    run(16'h0005, 32'h1);
    chk("status", 32'h042, st & 32'h3ff);
    chk_dst(8, 128'h2a2a2a2a3132332b);
    rc(`REG_DEST_PTR, dst_a + 32'h8, "dest ptr");
    rc(`REG_DIGIT_COUNT, 32'h5, "count");
    rc(`REG_SOURCE_PTR, src_a, "source ptr");
    rc(`REG_CHAR_HOLDING, 32'h0, "holding");
    rc(`REG_SCRATCH, 32'h0, "scratch");
    rc(`REG_PATTERN_PTR, pat_a + 32'hb, "pattern ptr");
    slow <= 1'b0;
    put(src_a, 1, 128'h0d);
    put(pat_a, 13, 128'h4323039104460104402a450100);
    run(16'h0001, 32'h1);
    chk("status", 32'h142, st & 32'h3ff);
    chk_dst(3, 128'h30202a);
    rc(`REG_DEST_PTR, dst_a + 32'h3, "dest ptr");
    put(src_a, 2, 128'h123c);
    put(pat_a, 4, 128'h47029200);
    run(16'h0003, 32'h3);
    chk("status", 32'h0d2, st & 32'h3ff);
    chk_dst(2, 128'h3233);
    rc(`REG_CTRL, 32'h2, "ctrl");
    put(src_a, 2, 128'h075c);
    put(pat_a, 5, 128'h402a470405);
    run(16'h0002, 32'h1);
    chk("status", 32'h128, st & 32'h3e8);
    rc(`REG_PATTERN_PTR, pat_a + 32'h4, "pattern ptr");
    rc(`REG_DIGIT_COUNT, 32'hfffe0002, "count");
    rc(`REG_DEST_PTR, dst_a, "dest ptr");
    rd(`REG_CHAR_HOLDING, d, r);
    chk("holding", 32'h202a, {16'h0, d[15:0]});
    put(pat_a + 32'h4, 2, 128'h9400);
    go(32'h1);
    chk("status", 32'h042, st & 32'h3ff);
    chk_dst(4, 128'h2a2a3735);
    rc(`REG_DIGIT_COUNT, 32'h2, "count");
    put(src_a, 1, 128'h1c);
    put(pat_a, 2, 128'h9200);
    run(16'h0001, 32'h1);
    chk("abort", 32'h4, st & 32'h4);
    rc(`REG_DIGIT_COUNT, 32'hffffffff, "count");
    rc(`REG_PATTERN_PTR, pat_a, "pattern ptr");
    put(src_a, 2, 128'h012c);
    put(pat_a, 2, 128'h9100);
    run(16'h0002, 32'h1);
    chk("abort", 32'h4, st & 32'h4);
    rc(`REG_PATTERN_PTR, pat_a + 32'h1, "pattern ptr");
    run(16'h0020, 32'h1);
    chk("abort", 32'h4, st & 32'h4);
    conclude();
  end
endmodule
`default_nettype wire
